// [shared/lpdt_pkg.sv]
// package of constants and types for the low power down timer
package lpdt_pkg;
  // register byte offsets
  localparam logic [7:0] LPDT_OFS_COUNT = 8'h00;
  localparam logic [7:0] LPDT_OFS_RELOAD = 8'h04;
  localparam logic [7:0] LPDT_OFS_CTRL = 8'h08;
  localparam logic [7:0] LPDT_OFS_SOFTIRQ = 8'h0C;
  localparam logic [7:0] LPDT_OFS_STATUS = 8'h10;
  localparam logic [7:0] LPDT_OFS_CLEAR = 8'h14;
  localparam logic [7:0] LPDT_OFS_ENABLE = 8'h18;
  // timer_control field positions
  localparam int LPDT_CTRL_BLOCK_EN = 0;
  localparam int LPDT_CTRL_REPEAT = 1;
  localparam int LPDT_CTRL_START = 2;
  localparam int LPDT_CTRL_DBG_FRZ_EN = 3;
  localparam int LPDT_CTRL_SW_FRZ = 4;
  localparam int LPDT_CTRL_W = 5;
  // status, clear and enable bit positions
  localparam int LPDT_EV_ZERO = 0;
  localparam int LPDT_EV_SOFT = 1;
  localparam int LPDT_EV_W = 2;
  localparam int LPDT_SOFT_W = 8;
  // reset values
  localparam logic [31:0] LPDT_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] LPDT_RELOAD_RST = 32'h0000_0000;
  localparam logic [4:0] LPDT_CTRL_RST = 5'h00;
  localparam logic [1:0] LPDT_EV_RST = 2'h0;
  // ahb constants
  localparam logic [1:0] LPDT_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] LPDT_HTRANS_SEQ = 2'h3;

  // one latched bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } lpdt_req_t;

  // counter commands from the register file
  typedef struct packed {
    logic start;
    logic stop;
    logic load_count;
    logic [31:0] count_data;
  } lpdt_cmd_t;
endpackage

// [design/lpdt_counter.sv]
// down counter core of the low power down timer
`timescale 1ns/100ps
`default_nettype none
module lpdt_counter
  import lpdt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire lpdt_cmd_t cmd,
  input wire logic [WIDTH-1:0] reload,
  input wire logic repeat_mode,
  input wire logic frozen,
  output logic [WIDTH-1:0] count,
  output logic running,
  output logic zero_pulse
);
  // elaboration check: the count must fit the 32-bit register word
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("lpdt_counter: WIDTH must be 2..32");
  end

  logic [WIDTH-1:0] count_next;
  logic running_next;
  logic zero_next;
  wire logic reload_zero = (reload == '0);
  wire logic at_one = (count == WIDTH'(1));
  wire logic stepping = running && !frozen;

  // next-state of count, run flag and the one-to-zero event
  always_comb begin
    count_next = count;
    running_next = running;
    zero_next = 1'b0;
    if (cmd.stop) begin
      count_next = '0;
      running_next = 1'b0;
    end else if (cmd.start) begin
      count_next = reload;
      running_next = !reload_zero;
    end else if (cmd.load_count) begin
      count_next = cmd.count_data[WIDTH-1:0];
    end else if (stepping) begin
      if (at_one) begin
        zero_next = 1'b1;
        if (repeat_mode) begin
          count_next = reload;
          running_next = !reload_zero;
        end else begin
          count_next = '0;
          running_next = 1'b0;
        end
      end else if (count == '0) begin
        running_next = 1'b0;
      end else begin
        count_next = count - WIDTH'(1);
      end
    end
  end

  // state registers, held while clock enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      running <= 1'b0;
      zero_pulse <= 1'b0;
    end else if (clk_en) begin
      count <= count_next;
      running <= running_next;
      zero_pulse <= zero_next;
    end
  end
endmodule
`default_nettype wire

// [design/lpdt_top.sv]
// low power down timer: ahb-lite register file, freeze control, interrupts
//
// What this block does
// - The counter is a 32-bit down counter on the always-on 32 kHz core clock.
// - A start loads the counter from the reload value, then it counts down once per tick.
// - A zero-crossing interrupt event rises when the running count steps from one to zero.
// - With repeat mode clear the counter stops at zero until a new start.
// - With repeat mode set the counter reloads at zero and keeps counting.
// - While the software-freeze bit is one the counter does not decrement.
// - With debug freeze enabled the halt input stops counting, otherwise it is ignored.
// - System reset returns all counter logic and registers to defaults.
// - A low-power request is accepted only while the counter is not running.
// - With the block already enabled and start clear, writing one to start loads the reload value and runs; a zero reload leaves start at zero.
// - Writing zero to start stops the counter, clears it, and raises no interrupt.
// - In one-shot mode the start bit clears itself on the one-to-zero step.
// - Clearing software freeze resumes from the held value without reloading.
`timescale 1ns/100ps
`default_nettype none
module lpdt_top
  import lpdt_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic halt_in,
  input wire logic low_power_req,
  output logic low_power_ack,
  output logic timer_active,
  output logic zero_crossing_irq,
  output logic irq
);
  // elaboration check: the register map holds a 32-bit count only
  if (COUNT_W != 32) begin : g_bad_width
    $error("lpdt_top: COUNT_W must be 32");
  end

  // halt pin crosses from the debug domain: two flip-flops
  logic halt_meta_reg;
  logic halt_sync_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_meta_reg <= 1'b0;
      halt_sync_reg <= 1'b0;
    end else if (clk_en) begin
      halt_meta_reg <= halt_in;
      halt_sync_reg <= halt_meta_reg;
    end
  end

  // low power request pin synchroniser
  logic lpr_meta_reg;
  logic lpr_sync_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lpr_meta_reg <= 1'b0;
      lpr_sync_reg <= 1'b0;
    end else if (clk_en) begin
      lpr_meta_reg <= low_power_req;
      lpr_sync_reg <= lpr_meta_reg;
    end
  end

  // ahb address phase capture
  lpdt_req_t req_reg;
  lpdt_req_t req_next;
  wire logic addr_phase = hsel && hready &&
                          (htrans == LPDT_HTRANS_NONSEQ || htrans == LPDT_HTRANS_SEQ);
  always_comb begin
    req_next = req_reg;
    if (hready) begin
      req_next.valid = addr_phase;
      req_next.write = hwrite;
      req_next.addr = haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) req_reg <= '0;
    else if (clk_en) req_reg <= req_next;
  end

  // data phase decode
  // read data is latched in the wait cycle, a write lands once as the wait ends
  wire logic wr_en = req_reg.valid && req_reg.write && hreadyout;
  wire logic rd_en = req_reg.valid && !req_reg.write && !hreadyout;
  wire logic hit_count = (req_reg.addr == LPDT_OFS_COUNT);
  wire logic hit_reload = (req_reg.addr == LPDT_OFS_RELOAD);
  wire logic hit_ctrl = (req_reg.addr == LPDT_OFS_CTRL);
  wire logic hit_soft = (req_reg.addr == LPDT_OFS_SOFTIRQ);
  wire logic hit_status = (req_reg.addr == LPDT_OFS_STATUS);
  wire logic hit_clear = (req_reg.addr == LPDT_OFS_CLEAR);
  wire logic hit_enable = (req_reg.addr == LPDT_OFS_ENABLE);
  wire logic wr_ctrl = wr_en && hit_ctrl;

  // software registers
  logic [31:0] reload_reg;
  logic [LPDT_CTRL_W-1:0] ctrl_reg;
  logic [LPDT_CTRL_W-1:0] ctrl_next;
  logic [LPDT_SOFT_W-1:0] soft_reg;
  logic [LPDT_EV_W-1:0] status_reg;
  logic [LPDT_EV_W-1:0] status_next;
  logic [LPDT_EV_W-1:0] enable_reg;

  // counter core interface
  lpdt_cmd_t cmd;
  logic [COUNT_W-1:0] count;
  logic running;
  logic zero_pulse;

  wire logic block_en = ctrl_reg[LPDT_CTRL_BLOCK_EN];
  wire logic start_wr = wr_ctrl && hwdata[LPDT_CTRL_START];
  wire logic stop_wr = wr_ctrl && !hwdata[LPDT_CTRL_START];
  wire logic sw_frozen = ctrl_reg[LPDT_CTRL_SW_FRZ];
  wire logic dbg_frozen = ctrl_reg[LPDT_CTRL_DBG_FRZ_EN] && halt_sync_reg;
  wire logic frozen = sw_frozen || dbg_frozen || !block_en;

  // start and stop come from writes of the start bit; count is writable
  assign cmd = '{start: start_wr && !ctrl_reg[LPDT_CTRL_START] && block_en,
                 stop: stop_wr,
                 load_count: wr_en && hit_count,
                 count_data: hwdata};

  lpdt_counter #(
    .WIDTH(COUNT_W)
  ) u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .cmd(cmd),
    .reload(reload_reg),
    .repeat_mode(ctrl_reg[LPDT_CTRL_REPEAT]),
    .frozen(frozen),
    .count(count),
    .running(running),
    .zero_pulse(zero_pulse)
  );

  // control next value: start bit mirrors whether the counter runs
  wire logic start_ok = start_wr && block_en && (reload_reg != '0);
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = hwdata[LPDT_CTRL_W-1:0];
      ctrl_next[LPDT_CTRL_START] = start_ok || (ctrl_reg[LPDT_CTRL_START] &&
                                    hwdata[LPDT_CTRL_START]);
    end else if (zero_pulse && !ctrl_reg[LPDT_CTRL_REPEAT]) begin
      ctrl_next[LPDT_CTRL_START] = 1'b0;
    end else if (ctrl_reg[LPDT_CTRL_START] && !running && !zero_pulse) begin
      ctrl_next[LPDT_CTRL_START] = running;
    end
  end

  // sticky status: a set in the same cycle as a clear wins
  wire logic [LPDT_EV_W-1:0] ev_set = {wr_en && hit_soft && (hwdata[LPDT_SOFT_W-1:0] != '0),
                                       zero_pulse};
  wire logic [LPDT_EV_W-1:0] ev_clr = (wr_en && hit_clear) ? hwdata[LPDT_EV_W-1:0] : '0;
  assign status_next = (status_reg & ~ev_clr) | ev_set;

  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_reg <= LPDT_RELOAD_RST;
      ctrl_reg <= LPDT_CTRL_RST;
      soft_reg <= '0;
      enable_reg <= LPDT_EV_RST;
      status_reg <= LPDT_EV_RST;
    end else if (clk_en) begin
      if (wr_en && hit_reload) reload_reg <= hwdata;
      if (wr_en && hit_soft) soft_reg <= hwdata[LPDT_SOFT_W-1:0];
      if (wr_en && hit_enable) enable_reg <= hwdata[LPDT_EV_W-1:0];
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
    end
  end

  // read data select
  wire logic [31:0] rd_mux =
    hit_count ? 32'(count) :
    hit_reload ? reload_reg :
    hit_ctrl ? {27'h0, ctrl_reg} :
    hit_soft ? {24'h0, soft_reg} :
    hit_status ? {30'h0, status_reg} :
    hit_enable ? {30'h0, enable_reg} : 32'h0000_0000;

  // outputs registered; one wait state on every access
  // a started timer refuses low power even while frozen, so its count is kept
  wire logic busy = running;
  wire logic ack_next = lpr_sync_reg && !busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      low_power_ack <= 1'b0;
      timer_active <= 1'b0;
      zero_crossing_irq <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= !(addr_phase && hreadyout);
      hrdata <= rd_en ? rd_mux : hrdata;
      hresp <= 1'b0;
      low_power_ack <= ack_next;
      timer_active <= running;
      zero_crossing_irq <= zero_pulse;
      irq <= |(status_next & enable_reg);
    end
  end
endmodule
`default_nettype wire

// [tb/lpdt_halt_src.sv]
// model of the debug halt source facing the timer
`timescale 1ns/100ps
`default_nettype none
module lpdt_halt_src (
  input wire logic hclk,
  input wire logic cpu_halt,
  output logic halt_in = 1'h0
);
  // halt follows the processor's own debug stop, one flop late
  always @(posedge hclk) begin
    halt_in <= cpu_halt;
  end
endmodule
`default_nettype wire

// [tb/lpdt_checker.sv]
// port checker for the low power down timer
`timescale 1ns/100ps
`default_nettype none
module lpdt_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic low_power_req,
  input wire logic low_power_ack,
  input wire logic timer_active,
  input wire logic zero_crossing_irq,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // an address phase that the slave takes
  wire logic acc = hsel && hready && htrans[1] && hreadyout && clk_en;
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_no_req;
    !low_power_req [*4];
  endsequence
  // bus, reset, pulse and power handshake relations
  a_bus_okay: assert property (!hresp) else $error("response not okay");
  a_wait_once: assert property (acc |=> s_wait) else $error("wait state wrong");
  a_no_stray: assert property (hreadyout && !acc |=> hreadyout) else $error("stray wait");
  a_reset_idle: assert property (disable iff (1'h0)
    !hresetn |-> hreadyout && !irq && !timer_active) else $error("not idle in reset");
  a_pulse_running: assert property (zero_crossing_irq |-> $past(timer_active))
    else $error("pulse while idle");
  a_pulse_single: assert property (zero_crossing_irq && clk_en |=> !zero_crossing_irq)
    else $error("pulse too long");
  a_ack_idle: assert property (timer_active && $past(timer_active) |-> !low_power_ack)
    else $error("ack while running");
  a_ack_no_req: assert property (s_no_req |-> !low_power_ack)
    else $error("ack without request");
  a_tick_freeze: assert property (!clk_en |=> $stable(timer_active) && $stable(hreadyout))
    else $error("state moved without tick");
endmodule
bind lpdt_top lpdt_checker u_lpdt_checker (.hclk, .hresetn, .clk_en, .hsel, .htrans, .hready,
  .hreadyout, .hresp, .low_power_req, .low_power_ack, .timer_active, .zero_crossing_irq, .irq);
`default_nettype wire

// [tb/low_power_down_timer_bench.sv]
// self-checking bench for the low power down timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %0t got %h want %h", $time, g, e); end end
module low_power_down_timer_bench;
  import lpdt_pkg::*;
  logic hclk = 0, hresetn = 1, clk_en = 1, hsel = 0, hwrite = 0, cpu_halt = 0, lp_req = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rd2;
  wire logic hreadyout, halt_in, low_power_ack, timer_active, zero_crossing_irq, irq;
  int err_total = 0, check_count = 0, n1, n2, r1, r2, nw;
  logic [31:0] mdl [8];
  always #20 hclk = ~hclk;
  lpdt_halt_src u_lpdt_halt_src (.hclk, .cpu_halt, .halt_in);
  lpdt_top u_lpdt_top (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .halt_in,
    .low_power_req(lp_req), .low_power_ack, .timer_active, .zero_crossing_irq, .irq);
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for ready or for a zero pulse
  task automatic wait_for(input bit p, input int lim, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((p ? zero_crossing_irq : hreadyout) !== 1'h1 && n < lim);
    if ((p ? zero_crossing_irq : hreadyout) !== 1'h1) begin
      err_total++;
      complete_run;
    end
  endtask
  // one ahb-lite single transfer, then the register model follows writes
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= LPDT_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_for(0, 40, nw);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(0, 40, nw);
    rd = hrdata;
    if (w) begin
      case (a)
        LPDT_OFS_CTRL: mdl[2] = (d[2] && mdl[1] == 0) ? d & 32'h1B : d & 32'h1F;
        LPDT_OFS_SOFTIRQ: mdl[3] = d & 32'hFF;
        LPDT_OFS_CLEAR: mdl[4] &= ~d;
        LPDT_OFS_ENABLE: mdl[6] = d & 32'h3;
        LPDT_OFS_STATUS, 8'h1C: ;
        default: mdl[a[4:2]] = d;
      endcase
      if (a == LPDT_OFS_SOFTIRQ && d[7:0] != 0) mdl[4] |= 32'h2;
    end
  endtask
  // reset, then every register and an unmapped word read as zero
  task automatic do_reset;
    hresetn <= 1'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    foreach (mdl[i]) mdl[i] = 32'h0;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      ahb(1'h0, 8'(i * 4), 32'h0);
      `CHK(rd, 32'h0)
    end
  endtask
  // one-shot run timed from five cycles after start to the zero pulse
  task automatic run_once(input logic [31:0] r, output int n);
    ahb(1'h1, LPDT_OFS_RELOAD, r);
    ahb(1'h1, LPDT_OFS_CTRL, 32'h5);
    repeat (5) @(posedge hclk);
    `CHK(low_power_ack, 1'h0)
    `CHK(timer_active, 1'h1)
    wait_for(1, 900, n);
    `CHK(n, r - 32'h3)
    `CHK(timer_active, 1'h0)
    mdl[2] = 32'h1;
    mdl[4] |= 32'h1;
    for (int i = 0; i < 5; i += 2) begin
      ahb(1'h0, 8'(i * 4), 32'h0);
      `CHK(rd, mdl[i])
    end
    `CHK(low_power_ack, 1'h1)
  endtask
  // main sequence
  initial begin
    r1 = $urandom(10406);
    do_reset;
    ahb(1'h1, LPDT_OFS_CTRL, 32'h5);
    ahb(1'h0, LPDT_OFS_CTRL, 32'h0);
    `CHK(rd, mdl[2])
    r1 = 20 + $urandom % 64;
    r2 = 20 + $urandom % 64;
    lp_req <= 1'h1;
    run_once(r1, n1);
    run_once(r2, n2);
    lp_req <= 1'h0;
    `CHK(n2 - n1, r2 - r1)
    ahb(1'h1, LPDT_OFS_ENABLE, 32'h1);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'h1)
    ahb(1'h1, LPDT_OFS_SOFTIRQ, 32'h5A);
    ahb(1'h1, LPDT_OFS_CLEAR, 32'h1);
    ahb(1'h0, LPDT_OFS_STATUS, 32'h0);
    `CHK(rd, mdl[4])
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'h0)
    ahb(1'h1, LPDT_OFS_CLEAR, 32'h2);
    ahb(1'h1, LPDT_OFS_RELOAD, 32'h3E8);
    ahb(1'h1, LPDT_OFS_CTRL, 32'h5);
    ahb(1'h1, LPDT_OFS_CTRL, 32'h15);
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    rd2 = rd;
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    `CHK(rd, rd2)
    ahb(1'h1, LPDT_OFS_CTRL, 32'h5);
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    `CHK(rd, rd2 - 32'h1)
    ahb(1'h1, LPDT_OFS_CTRL, 32'hD);
    cpu_halt <= 1'h1;
    repeat (4) @(posedge hclk);
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    rd2 = rd;
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    `CHK(rd, rd2)
    ahb(1'h1, LPDT_OFS_CTRL, 32'h5);
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    `CHK(rd, rd2 - 32'h1)
    cpu_halt <= 1'h0;
    ahb(1'h1, LPDT_OFS_CTRL, 32'h1);
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'h0, LPDT_OFS_STATUS, 32'h0);
    `CHK(rd, mdl[4])
    ahb(1'h1, LPDT_OFS_COUNT, 32'hA5A5_0F0F);
    ahb(1'h0, LPDT_OFS_COUNT, 32'h0);
    `CHK(rd, mdl[0])
    ahb(1'h1, LPDT_OFS_RELOAD, 32'h1E);
    ahb(1'h1, LPDT_OFS_CTRL, 32'h7);
    n1 = 0;
    repeat (200) begin
      @(posedge hclk);
      if (zero_crossing_irq === 1'h1) n1++;
    end
    `CHK(n1, 6)
    clk_en <= 1'h0;
    repeat (10) @(posedge hclk);
    clk_en <= 1'h1;
    do_reset;
    complete_run;
  end
endmodule
`default_nettype wire
